/* File: hdl/tpg_crc32.sv */
`timescale 1ns/100ps
`include "tpg_map.svh"
module tpg_crc32 (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic sys_rst,
   // Byte stream in, check sequence out
   tpg_crc_if.eng    crc
);
   import tpg_pkg::*;

   logic [31:0] remainder;
   logic [31:0] next_remainder;

   // Reflected CRC-32, one byte per clock, LSB first as on the wire
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ `TPG_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // Held at seed between frames so byte 0 always starts clean
   always_comb begin
      next_remainder = remainder;
      if (crc.init) begin
         next_remainder = `TPG_CRC_INIT;
      end else if (crc.valid) begin
         next_remainder = crc_byte(remainder, crc.data);
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         remainder <= `TPG_CRC_INIT;
      end else begin
         remainder <= next_remainder;
      end
   end

   // Final complement; low byte goes out first
   assign crc.fcs = ~remainder;
endmodule // tpg_crc32

/* File: hdl/tpg_crc_if.sv */
`timescale 1ns/100ps
interface tpg_crc_if;
   logic        init;
   logic        valid;
   logic [7:0]  data;
   logic [31:0] fcs;

   modport gen (output init, output valid, output data, input fcs);
   modport eng (input init, input valid, input data, output fcs);
endinterface // tpg_crc_if

/* File: hdl/tpg_generator.sv */
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "tpg_map.svh"
module tpg_generator #(
   parameter int unsigned BURST_FRAMES = `TPG_BURST_FRAMES,
   parameter int unsigned BLOCK_FRAMES = `TPG_BLOCK_FRAMES
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   // Wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [9:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Generated frame stream toward the media side
   output logic             tx_en,
   output logic      [7:0]  tx_data,
   // CRC error event from the receive checker, same clock
   input  wire logic        crc_err_seen
);
   import tpg_pkg::*;

   localparam int unsigned GAP_SHORT = `TPG_NS_TO_CYC(`TPG_GAP_SHORT_NS);
   localparam int unsigned GAP_LONG  = `TPG_NS_TO_CYC(`TPG_GAP_LONG_NS);

   // Register file and bus state
   logic [15:0]   control;
   logic [15:0]   next_control;
   logic [15:0]   payload;
   logic [15:0]   next_payload;
   logic [7:0]    crc_cnt;
   logic [7:0]    next_crc_cnt;
   logic          next_ack;
   logic [31:0]   next_dat;
   logic [7:0]    reg_idx;
   logic          bus_req;

   // Generator state
   tpg_state_type state;
   tpg_state_type next_state;
   tpg_cfg_type   cfg;
   tpg_cfg_type   next_cfg;
   logic [13:0]   byte_idx;
   logic [13:0]   next_byte_idx;
   logic [10:0]   gap_cnt;
   logic [10:0]   next_gap_cnt;
   logic [24:0]   total_cnt;
   logic [24:0]   next_total_cnt;
   logic [13:0]   block_cnt;
   logic [13:0]   next_block_cnt;
   logic [15:0]   lfsr;
   logic [15:0]   next_lfsr;
   logic          go_q;
   logic          armed;
   logic          next_armed;
   logic          next_tx_en;
   logic [7:0]    next_tx_data;

   // Generator decode
   logic          go;
   logic          start;
   logic [13:0]   len;
   logic          in_fcs;
   logic          last_byte;
   logic          block_end;
   logic          stop_now;
   logic [1:0]    fcs_k;
   logic [7:0]    cur_byte;

   tpg_crc_if     crc_if ();

   // RL5 length code decode
   // Frame size in bytes, check sequence included
   function automatic logic [13:0] frame_len(input logic [1:0] sel);
      case (sel)
         2'b00:   frame_len = `TPG_LEN_125;
         2'b01:   frame_len = `TPG_LEN_64;
         2'b10:   frame_len = `TPG_LEN_1518;
         default: frame_len = `TPG_LEN_JUMBO;
      endcase
   endfunction

   // Bus slave: one wait state, then a registered ack
   always_comb begin
      reg_idx      = wb_adr_i[9:2];
      bus_req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      next_ack     = bus_req;
      next_dat     = wb_dat_o;
      next_control = control;
      next_payload = payload;
      next_crc_cnt = crc_cnt;
      // RL15 saturating error count
      if (crc_err_seen && crc_cnt != `TPG_CRC_COUNT_MAX) begin
         next_crc_cnt = crc_cnt + 8'h01;
      end
      if (bus_req && !wb_we_i) begin
         case (reg_idx)
            `TPG_IDX_CONTROL:   next_dat = {16'h0000, control};
            `TPG_IDX_PAYLOAD:   next_dat = {16'h0000, payload};
            `TPG_IDX_STATUS:    next_dat = {6'h00, total_cnt, state != TPG_IDLE};
            `TPG_IDX_CRC_COUNT: begin
               next_dat = {24'h000000, crc_cnt};
               // RL15 clear on read, a same-cycle error survives
               next_crc_cnt = crc_err_seen ? 8'h01 : `TPG_CRC_COUNT_RST;
            end
            default:            next_dat = 32'h00000000;
         endcase
      end
      // Write lands at the edge that samples ack, while the master still holds it
      if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i) begin
         // Byte lanes 0 and 1 only; upper lanes have no storage
         case (reg_idx)
            `TPG_IDX_CONTROL: begin
               if (wb_sel_i[0]) begin
                  next_control[7:0] = wb_dat_i[7:0];
               end
               if (wb_sel_i[1]) begin
                  next_control[15:8] = wb_dat_i[15:8];
               end
            end
            `TPG_IDX_PAYLOAD: begin
               if (wb_sel_i[0]) begin
                  next_payload[7:0] = wb_dat_i[7:0];
               end
               if (wb_sel_i[1]) begin
                  next_payload[15:8] = wb_dat_i[15:8];
               end
            end
            default: next_control = control;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         control  <= `TPG_CONTROL_RST;
         payload  <= `TPG_PAYLOAD_RST;
         crc_cnt  <= `TPG_CRC_COUNT_RST;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         control  <= next_control;
         payload  <= next_payload;
         crc_cnt  <= next_crc_cnt;
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

   // Current byte of the frame, chosen by position
   always_comb begin
      len       = frame_len(cfg.len_sel);
      in_fcs    = byte_idx >= len - `TPG_FCS_BYTES;
      last_byte = byte_idx == len - 14'd1;
      fcs_k     = 2'(byte_idx - (len - `TPG_FCS_BYTES));
      // RL16 field order on the wire
      if (byte_idx < `TPG_DA_LAST) begin
         cur_byte = 8'hFF;
      end else if (byte_idx == `TPG_DA_LAST) begin
         // RL7 destination low nibble
         cur_byte = {4'hF, cfg.da};
      end else if (byte_idx < `TPG_SA_LAST) begin
         cur_byte = 8'hFF;
      end else if (byte_idx == `TPG_SA_LAST) begin
         // RL8 source low nibble
         cur_byte = {4'hF, cfg.sa};
      end else if (!in_fcs) begin
         // RL9 random or fixed payload
         if (cfg.rnd) begin
            cur_byte = lfsr[7:0];
         end else begin
            // RL11 pattern repeats, high byte first
            cur_byte = byte_idx[0] ? cfg.pattern[7:0] : cfg.pattern[15:8];
         end
      end else begin
         // RL10 corrupt first check byte on request
         cur_byte = crc_if.fcs[{fcs_k, 3'b000} +: 8]
                    ^ ((cfg.bad_fcs && fcs_k == 2'd0) ? 8'hFF : 8'h00);
      end
   end

   // Check sequence engine sees every byte ahead of the check sequence
   assign crc_if.init  = (state != TPG_FRAME);
   assign crc_if.valid = (state == TPG_FRAME) & ~in_fcs;
   assign crc_if.data  = cur_byte;

   tpg_crc32 u_crc (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .crc      (crc_if.eng)
   );

   // Frame sequencer
   always_comb begin
      // RL1 both bits must be set
      go             = control[`TPG_BIT_ENABLE] & control[`TPG_BIT_RUN];
      start          = go & ~go_q;
      block_end      = block_cnt == 14'(BLOCK_FRAMES - 1);
      stop_now       = 1'b0;
      next_state     = state;
      next_cfg       = cfg;
      next_byte_idx  = byte_idx;
      next_gap_cnt   = gap_cnt;
      next_total_cnt = total_cnt;
      next_block_cnt = block_cnt;
      next_lfsr      = lfsr;
      next_armed     = armed | start;
      next_tx_en     = (state == TPG_FRAME);
      next_tx_data   = (state == TPG_FRAME) ? cur_byte : 8'h00;
      case (state)
         TPG_IDLE: begin
            // RL12 settings captured only on a fresh start
            if (armed && go) begin
               next_armed     = start;
               next_cfg.cont     = control[`TPG_BIT_CONT];
               next_cfg.len_sel  = control[`TPG_LEN_HI:`TPG_LEN_LO];
               next_cfg.long_gap = control[`TPG_BIT_GAP];
               next_cfg.da       = control[`TPG_DA_HI:`TPG_DA_LO];
               next_cfg.sa       = control[`TPG_SA_HI:`TPG_SA_LO];
               next_cfg.rnd      = control[`TPG_BIT_RAND];
               next_cfg.bad_fcs  = control[`TPG_BIT_BADFCS];
               // RL13 pattern captured with the rest
               next_cfg.pattern  = payload;
               next_total_cnt = 25'h0000000;
               next_block_cnt = 14'h0000;
               next_byte_idx  = 14'h0000;
               next_state     = TPG_FRAME;
            end else if (!go) begin
               next_armed = 1'b0;
            end
         end
         TPG_FRAME: begin
            next_byte_idx = byte_idx + 14'd1;
            if (cfg.rnd && byte_idx > `TPG_SA_LAST && !in_fcs) begin
               next_lfsr = {1'b0, lfsr[15:1]} ^ (lfsr[0] ? `TPG_LFSR_TAPS : 16'h0000);
            end
            if (last_byte) begin
               next_total_cnt = total_cnt + 25'd1;
               // RL2 count in blocks of ten thousand
               next_block_cnt = block_end ? 14'h0000 : block_cnt + 14'd1;
               if (cfg.cont) begin
                  // RL3 live continuous bit off ends at boundary
                  stop_now = block_end & ~control[`TPG_BIT_CONT];
               end else begin
                  // RL4 bounded burst ends by itself
                  stop_now = total_cnt == 25'(BURST_FRAMES - 1);
               end
               next_byte_idx = 14'h0000;
               // RL1 stop at the frame end, never mid-frame
               if (stop_now || !go || armed) begin
                  next_state = TPG_IDLE;
               end else begin
                  next_state = TPG_GAP;
                  // RL6 idle time between frames
                  next_gap_cnt = cfg.long_gap ? 11'(GAP_LONG - 1) : 11'(GAP_SHORT - 1);
               end
            end
         end
         TPG_GAP: begin
            next_gap_cnt = gap_cnt - 11'd1;
            // RL12 a restart abandons the gap and reloads settings
            if (!go || armed) begin
               next_state = TPG_IDLE;
            end else if (gap_cnt == 11'd0) begin
               next_state = TPG_FRAME;
            end
         end
         default: next_state = TPG_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state     <= TPG_IDLE;
         cfg       <= '0;
         byte_idx  <= 14'h0000;
         gap_cnt   <= 11'h000;
         total_cnt <= 25'h0000000;
         block_cnt <= 14'h0000;
         lfsr      <= `TPG_LFSR_SEED;
         go_q      <= 1'b0;
         armed     <= 1'b0;
         tx_en     <= 1'b0;
         tx_data   <= 8'h00;
      end else begin
         state     <= next_state;
         cfg       <= next_cfg;
         byte_idx  <= next_byte_idx;
         gap_cnt   <= next_gap_cnt;
         total_cnt <= next_total_cnt;
         block_cnt <= next_block_cnt;
         lfsr      <= next_lfsr;
         go_q      <= go;
         armed     <= next_armed;
         tx_en     <= next_tx_en;
         tx_data   <= next_tx_data;
      end
   end
endmodule // tpg_generator

/* File: hdl/tpg_map.svh */
// Summary of operation
// RL1 - Frames are generated only while both enable and run bits are one.
// RL2 - Duration bit one: send frames endlessly, counted in blocks of ten thousand.
// RL3 - Continuous mode turned off: stop at the next ten-thousand frame boundary.
// RL4 - Duration bit zero: send thirty million frames after start, then stop.
// RL5 - Length field selects 125, 64, 1518 or 10000 byte frames.
// RL6 - Gap bit selects 8192 ns or 96 ns idle time between frames.
// RL7 - Destination address is all ones with its low nibble from bits 9:6.
// RL8 - Source address is all ones with its low nibble from bits 5:2.
// RL9 - Payload type one gives a random payload, zero the fixed pattern.
// RL10 - Bad FCS bit one corrupts the check sequence, zero keeps it correct.
// RL11 - Fixed payload repeats the 16-bit pattern register through every payload.
// RL12 - Control bits 13:0 apply only after run is cleared and set again; bit 13 cleared mid-run still ends the run at a block boundary.
// RL13 - Pattern register changes apply only after run is cleared and set again.
// RL14 - Software should not start the generator on a live network.
// RL15 - Eight-bit CRC error counter saturates at 0xFF and clears when read.
// RL16 - Frame is DA, SA, payload, CRC-32; length includes the check sequence.
`ifndef TPG_MAP_SVH
`define TPG_MAP_SVH

// Register indexes; byte address is four times the index
`define TPG_IDX_CRC_COUNT 8'h17
`define TPG_IDX_CONTROL 8'h1D
`define TPG_IDX_PAYLOAD 8'h1E
`define TPG_IDX_STATUS 8'h1F

// Control register fields
`define TPG_BIT_ENABLE 15
`define TPG_BIT_RUN 14
`define TPG_BIT_CONT 13
`define TPG_LEN_HI 12
`define TPG_LEN_LO 11
`define TPG_BIT_GAP 10
`define TPG_DA_HI 9
`define TPG_DA_LO 6
`define TPG_SA_HI 5
`define TPG_SA_LO 2
`define TPG_BIT_RAND 1
`define TPG_BIT_BADFCS 0

// Reset values
`define TPG_CONTROL_RST 16'h0040
`define TPG_PAYLOAD_RST 16'h0000
`define TPG_CRC_COUNT_RST 8'h00
`define TPG_CRC_COUNT_MAX 8'hFF

// Frame layout
`define TPG_LEN_125 14'd125
`define TPG_LEN_64 14'd64
`define TPG_LEN_1518 14'd1518
`define TPG_LEN_JUMBO 14'd10000
`define TPG_DA_LAST 14'd5
`define TPG_SA_LAST 14'd11
`define TPG_HDR_BYTES 14'd12
`define TPG_FCS_BYTES 14'd4
`define TPG_CRC_POLY 32'hEDB88320
`define TPG_CRC_INIT 32'hFFFFFFFF
`define TPG_LFSR_SEED 16'hACE1
`define TPG_LFSR_TAPS 16'hB400

// Frame counts
`define TPG_BLOCK_FRAMES 10000
`define TPG_BURST_FRAMES 30000000

// Timing
`define TPG_CLK_PERIOD_PS 5000
`define TPG_GAP_SHORT_NS 96
`define TPG_GAP_LONG_NS 8192
`define TPG_NS_TO_CYC(ns) (((ns) * 1000 + `TPG_CLK_PERIOD_PS - 1) / `TPG_CLK_PERIOD_PS)

`endif

/* File: hdl/tpg_pkg.sv */
package tpg_pkg;

   // Generator sequencing
   typedef enum logic [1:0] {
      TPG_IDLE  = 2'b00,
      TPG_FRAME = 2'b01,
      TPG_GAP   = 2'b10
   } tpg_state_type;

   // Configuration captured when a run starts
   typedef struct packed {
      logic        cont;
      logic [1:0]  len_sel;
      logic        long_gap;
      logic [3:0]  da;
      logic [3:0]  sa;
      logic        rnd;
      logic        bad_fcs;
      logic [15:0] pattern;
   } tpg_cfg_type;

endpackage

/* File: verification/tpg_generator_assertions.sv */
`timescale 1ns/100ps
module tpg_generator_assertions #(
   parameter int unsigned BURST_FRAMES = 30000000,
   parameter int unsigned BLOCK_FRAMES = 10000
) (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        sys_rst,
   // Register bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [9:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Frame stream and error event
   input wire logic        tx_en,
   input wire logic [7:0]  tx_data,
   input wire logic        crc_err_seen
);
   logic [13:0] run_len;
   logic [13:0] next_run_len;
   logic [7:0]  idx;

   // Bytes of the frame in progress; wide enough for jumbo
   always_comb begin
      next_run_len = tx_en ? run_len + 14'h0001 : 14'h0000;
   end
   always_ff @(posedge core_clk) begin
      run_len <= sys_rst ? 14'h0000 : next_run_len;
   end
   assign idx = wb_adr_i[9:2];

   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   chk_upper_zero: assert property (wb_ack_o && !wb_we_i && idx != 8'h1F |->
      wb_dat_o[31:16] == 16'h0000) else $error("upper read bits not zero");
   chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i &&
      !(idx inside {8'h17, 8'h1D, 8'h1E, 8'h1F}) |-> wb_dat_o == 32'h00000000)
      else $error("unmapped read not zero");
   chk_idle_zero: assert property (!tx_en |-> tx_data == 8'h00)
      else $error("data on idle line");
   chk_frame_len: assert property ($fell(tx_en) |->
      run_len inside {14'd64, 14'd125, 14'd1518, 14'd10000})
      else $error("frame length not selectable");
   chk_da_lead: assert property ($rose(tx_en) |-> (tx_en && tx_data == 8'hFF) [*5])
      else $error("destination lead bytes wrong");
   chk_sa_lead: assert property ($rose(tx_en) |-> ##6 (tx_data == 8'hFF) [*5])
      else $error("source lead bytes wrong");
   chk_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !tx_en && !wb_ack_o)
      else $error("activity after reset");

   // Main scenarios seen
   cover property ($fell(tx_en) && run_len == 14'd10000);
   cover property ($fell(tx_en) && run_len == 14'd64);
   cover property (wb_ack_o && !wb_we_i && idx == 8'h17);
endmodule // tpg_generator_assertions

/* File: verification/tpg_generator_bench.sv */
`timescale 1ns/100ps
module tpg_generator_bench;
   localparam int BURST   = 2;
   localparam int BLOCK   = 3;
   localparam int LENS[4] = '{125, 64, 1518, 10000};
   logic        core_clk = 1'b0;
   logic        sys_rst  = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i  = 1'b0;
   logic [9:0]  wb_adr_i = 10'h000;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h00000000;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        tx_en;
   logic [7:0]  tx_data;
   logic        crc_err_seen;
   logic [31:0] rd;
   bit          ok;
   int          base;
   int          mismatches  = 0;
   int          comparisons = 0;

   // Free-running core clock
   always #2.5 core_clk = ~core_clk;

   tpg_generator #(.BURST_FRAMES(BURST), .BLOCK_FRAMES(BLOCK)) tpg_generator_i (
      .core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_en(tx_en), .tx_data(tx_data),
      .crc_err_seen(crc_err_seen));
   tpg_link_partner tpg_link_partner_i (.core_clk(core_clk), .sys_rst(sys_rst),
      .tx_en(tx_en), .tx_data(tx_data), .crc_err_seen(crc_err_seen));

   task end_of_test;
      $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Classic single cycle; held until ack is sampled high
   task wb(input logic we, input logic [9:0] adr, input logic [15:0] dat);
      int n;
      @(posedge core_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'b11, we, adr, 4'h3};
      wb_dat_i <= {16'h0000, dat};
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (wb_ack_o !== 1'b1) begin
         mismatches++;
         end_of_test();
      end
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
   endtask

   task wait_frames(input int n, input int lim, output bit hit);
      hit = 1'b0;
      for (int k = 0; k < lim && !hit; k++) begin
         @(posedge core_clk);
         hit = (tpg_link_partner_i.frames >= n);
      end
   endtask

   // Quiet longer than the longest gap means the run is over
   task wait_idle;
      for (int k = 0; k < 40000; k++) begin
         @(posedge core_clk);
         if (tpg_link_partner_i.idle > 1700) return;
      end
      mismatches++;
      end_of_test();
   endtask

   // Model of the last frame: addresses, then fixed or random payload
   task frame_cmp(input int len, input logic [3:0] da, input logic [3:0] sa,
                  input logic [15:0] pat, input logic rnd);
      logic [7:0] q[$];
      logic [7:0] e;
      int         bad;
      int         same;
      q = tpg_link_partner_i.last;
      bad = 0;
      same = 0;
      check("frame length", q.size(), len);
      for (int k = 0; k < len - 4 && k < q.size(); k++) begin
         e = (k == 5) ? {4'hF, da} : (k == 11) ? {4'hF, sa} : 8'hFF;
         if (k >= 12) e = k[0] ? pat[7:0] : pat[15:8];
         if (k < 12 || !rnd) bad += (q[k] !== e);
         else same += (q[k] === e);
      end
      check("frame bytes", bad, 0);
      if (rnd) check("random payload", same < len - 16, 1);
   endtask

   // Bounded burst for one length code
   task run_case(input int i);
      logic [15:0] pat;
      logic [3:0]  da;
      logic [3:0]  sa;
      logic        gap;
      logic        bad;
      pat = 16'($urandom);
      da = 4'($urandom);
      sa = 4'($urandom);
      gap = (i % 2 == 1);
      bad = (i % 2 == 1);
      wb(1'b1, 10'h078, pat);
      base = tpg_link_partner_i.frames;
      wb(1'b1, 10'h074, {3'b110, 2'(i), gap, da, sa, i == 2, bad});
      wait_frames(base + BURST, 30000, ok);
      check("burst started", ok, 1);
      wait_idle();
      check("burst frames", tpg_link_partner_i.frames - base, BURST);
      check("gap cycles", tpg_link_partner_i.gap, gap ? 1639 : 20);
      frame_cmp(LENS[i], da, sa, pat, i == 2);
      wb(1'b0, 10'h07C, 16'h0000);
      check("status", rd, BURST * 2);
      wb(1'b0, 10'h05C, 16'h0000);
      check("crc count", rd, bad ? BURST : 0);
      wb(1'b0, 10'h05C, 16'h0000);
      check("crc cleared", rd, 0);
      wb(1'b1, 10'h074, 16'h8000);
   endtask

   // Main sequence
   initial begin
      void'($urandom(23730));
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'b0;
      wb(1'b0, 10'h074, 16'h0000);
      check("control reset", rd, 32'h00000040);
      wb(1'b0, 10'h078, 16'h0000);
      check("payload reset", rd, 0);
      wb(1'b1, 10'h100, 16'hFFFF);
      wb(1'b0, 10'h100, 16'h0000);
      check("unmapped read", rd, 0);
      base = tpg_link_partner_i.frames;
      wb(1'b1, 10'h074, 16'h4000);
      wait_frames(base + 1, 200, ok);
      check("run without enable", ok, 0);
      wb(1'b1, 10'h078, 16'h1234);
      base = tpg_link_partner_i.frames;
      wb(1'b1, 10'h074, 16'hE969);
      wait_frames(base + 300, 40000, ok);
      check("continuous run", ok, 1);
      wb(1'b1, 10'h078, 16'hBEEF);
      wb(1'b1, 10'h074, 16'hCBE9);
      wait_idle();
      check("block boundary", (tpg_link_partner_i.frames - base) % BLOCK, 0);
      frame_cmp(64, 4'h5, 4'hA, 16'h1234, 1'b0);
      wb(1'b0, 10'h05C, 16'h0000);
      check("crc saturated", rd, 32'h000000FF);
      wb(1'b1, 10'h074, 16'h8000);
      for (int i = 0; i < 4; i++) run_case(i);
      end_of_test();
   end
endmodule // tpg_generator_bench

bind tpg_generator tpg_generator_assertions #(
   .BURST_FRAMES(BURST_FRAMES), .BLOCK_FRAMES(BLOCK_FRAMES)
) tpg_generator_assertions_i (
   .core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_en(tx_en), .tx_data(tx_data),
   .crc_err_seen(crc_err_seen));

/* File: verification/tpg_link_partner.sv */
`timescale 1ns/100ps
// isolated test link
// Far end of a bench-only link, so no live traffic shares it
module tpg_link_partner (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   // Frame stream from the generator
   input  wire logic       tx_en,
   input  wire logic [7:0] tx_data,
   // One pulse per failed check sequence
   output logic            crc_err_seen
);
   logic [7:0]  frame[$];
   logic [7:0]  last[$];
   logic [31:0] crc;
   int          frames;
   int          gap;
   int          idle;

   // Gather bytes, check the sequence when the line goes quiet
   always @(posedge core_clk) begin
      crc_err_seen <= 1'b0;
      if (sys_rst) begin
         frame.delete();
         frames <= 0;
         idle   <= 0;
      end else if (tx_en) begin
         frame.push_back(tx_data);
         if (frame.size() == 1) gap <= idle;
         idle <= 0;
      end else begin
         idle <= idle + 1;
         if (frame.size() > 4) begin
            crc = 32'hFFFFFFFF;
            for (int i = 0; i < frame.size() - 4; i++) begin
               crc ^= {24'h000000, frame[i]};
               repeat (8) crc = crc[0] ? (crc >> 1) ^ 32'hEDB88320 : crc >> 1;
            end
            crc_err_seen <= ({frame[$], frame[$-1], frame[$-2], frame[$-3]} !== ~crc);
            last = frame;
            frames <= frames + 1;
            frame.delete();
         end
      end
   end
endmodule // tpg_link_partner
